// ===== rtl/tmo_pkg.sv
// Purpose: Shared constants for the timer overflow-flag and one-shot qualifier.
// Assumes: 16-bit counter, two mode-select bits.
// Notes: Mode codes name the counting modes seen by the qualifier.
package tmo_pkg;
  // Counter width.
  localparam int CNT_W = 16;
  // Counter extremes.
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  // Mode-select codes {hi, lo}.
  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_CLR_EDGE = 2'h1;
  localparam logic [1:0] MODE_FREE = 2'h2;
  localparam logic [1:0] MODE_CLR_MATCH = 2'h3;
  // One-shot pulse length in count clocks.
  localparam logic [15:0] OS_LEN = 16'h0001;
  // Reset value of the overflow flag.
  localparam logic FLAG_RST = 1'b0;
  // One-shot states.
  typedef enum logic [0:0] {TMO_OS_IDLE, TMO_OS_PULSE} tmo_os_state_t;
endpackage

// ===== rtl/tmo_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for a pin input.
// Assumes: Single clock domain, clock enable freezes state.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/100ps
module tmo_sync (
  input wire logic clk_in, // System clock.
  input wire logic rst_in, // Synchronous reset, active high.
  input wire logic ce_in, // Clock enable.
  input wire logic pin_in, // Asynchronous pin level.
  output logic level_out, // Filtered level.
  output logic rise_out // One-cycle pulse on filtered rise.
);
  logic s1; // First stage.
  logic s2; // Second stage.
  logic s3; // Third stage.
  logic agree; // Second and third stages agree.
  // Agreement between the later stages.
  assign agree = (s2 == s3);
  // Shift chain and filtered level.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_out <= 1'b0;
      rise_out <= 1'b0;
    end
    else if (ce_in)
    begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      level_out <= agree ? s3 : level_out;
      rise_out <= agree & s3 & ~level_out;
    end
  end
endmodule

// ===== rtl/tmo_ctl.sv
// Purpose: Overflow flag and one-shot qualification of a 16-bit timer.
// Assumes: Count pulses arrive as one-cycle enables on clk_in.
// Notes: Counter lives in this block; compare value and mode bits arrive as input ports.
// Functional notes
// RL1 - Any counter wrap sets overflow flag.
// RL2 - Match-clear from FFFFH also sets flag.
// RL3 - Clear ignored until counter reaches 0001H, an edge clear or a stop.
// RL4 - One-shot works in free and edge modes.
// RL5 - No one-shot in match-clear mode.
// RL6 - Mode bits 00 stop the counter.
// RL7 - Write zero clears flag outside window.
`timescale 1ns/100ps
module tmo_ctl (
  input wire logic clk_in, // System clock, 200 MHz.
  input wire logic rst_in, // Synchronous reset, active high.
  input wire logic ce_in, // Clock enable, freezes all state when low.
  input wire logic count_pulse_in, // One-cycle count clock enable.
  input wire logic mode_select_hi_in, // Upper mode-select bit.
  input wire logic mode_select_lo_in, // Lower mode-select bit.
  input wire logic [15:0] compare_capture_reg_a_in, // Compare value.
  input wire logic external_edge_input_in, // Pin that clears in edge mode.
  input wire logic flag_clear_in, // Software writes 0 to the flag.
  input wire logic oneshot_trig_in, // Software one-shot trigger.
  output logic overflow_flag_out, // Overflow flag.
  output logic [15:0] count_value_reg_out, // Counter value.
  output logic match_capture_irq_out, // Match pulse.
  output logic oneshot_out // One-shot pulse output.
);
  logic [15:0] cnt; // Counter.
  logic flag; // Overflow flag.
  logic window; // Post-wrap window where clears are ignored.
  logic oneshot; // One-shot output.
  logic irq; // Match pulse register.
  logic [15:0] os_cnt; // One-shot length counter.
  tmo_pkg::tmo_os_state_t os_state; // One-shot state.
  tmo_pkg::tmo_os_state_t next_os_state; // Next one-shot state.
  logic edge_lvl; // Filtered edge pin level.
  logic edge_rise; // Filtered rising edge of the pin.
  logic [1:0] mode; // Combined mode bits.
  logic running; // Timer is operating.
  logic step; // Counter advances this cycle.
  logic is_match; // Counter equals compare value.
  logic wrap_nat; // Natural wrap from FFFFH.
  logic wrap_match; // Match-clear from FFFFH.
  logic wrap_any; // Any wrap event.
  logic match_clr; // Match-clear in match mode.
  logic edge_clr; // Edge clear in edge mode.
  logic os_allowed; // Mode permits a one-shot.
  logic clear_ok; // Software clear takes effect.
  logic os_done; // One-shot length reached.
  logic [15:0] next_cnt; // Next counter value.

  // Synchronise the external pin.
  tmo_sync u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .pin_in(external_edge_input_in),
    .level_out(edge_lvl),
    .rise_out(edge_rise)
  );

  // Mode decode.
  assign mode = {mode_select_hi_in, mode_select_lo_in};
  // RL6 stop decode: 00 halts counting.
  assign running = (mode != tmo_pkg::MODE_STOP);
  assign step = running & count_pulse_in;
  assign is_match = (cnt == compare_capture_reg_a_in);
  assign match_clr = step & (mode == tmo_pkg::MODE_CLR_MATCH) & is_match;
  assign edge_clr = running & edge_rise & (mode == tmo_pkg::MODE_CLR_EDGE);
  // RL1 natural wrap detection.
  assign wrap_nat = step & (cnt == tmo_pkg::CNT_MAX) & ~match_clr;
  // RL2 match clear from FFFFH.
  assign wrap_match = match_clr & (cnt == tmo_pkg::CNT_MAX);
  assign wrap_any = wrap_nat | wrap_match;
  // RL3 clear blocked in window.
  assign clear_ok = flag_clear_in & ~window & ~wrap_any;
  // RL4 and RL5 mode qualification for one-shot.
  assign os_allowed = (mode == tmo_pkg::MODE_FREE) | (mode == tmo_pkg::MODE_CLR_EDGE);
  assign os_done = (os_cnt >= tmo_pkg::OS_LEN);

  // Next counter value: clear on match or edge, else increment.
  always_comb
  begin
    next_cnt = cnt;
    if (edge_clr | match_clr)
    begin
      next_cnt = tmo_pkg::CNT_ZERO;
    end
    else if (step)
    begin
      next_cnt = cnt + tmo_pkg::CNT_ONE;
    end
  end

  // One-shot state decode.
  always_comb
  begin
    next_os_state = os_state;
    case (os_state)
      tmo_pkg::TMO_OS_IDLE:
      begin
        // RL5 trigger ignored when not allowed.
        if (oneshot_trig_in & os_allowed)
        begin
          next_os_state = tmo_pkg::TMO_OS_PULSE;
        end
      end
      tmo_pkg::TMO_OS_PULSE:
      begin
        // RL4 pulse ends after its length or on leaving an allowed mode.
        if ((step & os_done) | ~os_allowed)
        begin
          next_os_state = tmo_pkg::TMO_OS_IDLE;
        end
      end
      default:
      begin
        next_os_state = tmo_pkg::TMO_OS_IDLE;
      end
    endcase
  end

  // Counter register.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cnt <= tmo_pkg::CNT_ZERO;
    end
    else if (ce_in)
    begin
      cnt <= next_cnt;
    end
  end

  // Overflow flag; a wrap wins over any clear.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      flag <= tmo_pkg::FLAG_RST;
    end
    else if (ce_in)
    begin
      // RL1 RL2 set on wrap.
      if (wrap_any)
      begin
        flag <= 1'b1;
      end
      // RL7 software clear.
      else if (clear_ok)
      begin
        flag <= 1'b0;
      end
    end
  end

  // Window opens on wrap and closes on a count step, an edge clear or a stop.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      window <= 1'b0;
    end
    else if (ce_in)
    begin
      // RL3 window tracking.
      if (wrap_any)
      begin
        window <= 1'b1;
      end
      else if (step | edge_clr | ~running)
      begin
        window <= 1'b0;
      end
    end
  end

  // Match pulse register.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      irq <= 1'b0;
    end
    else if (ce_in)
    begin
      irq <= match_clr;
    end
  end

  // One-shot state, length counter and output.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      os_state <= tmo_pkg::TMO_OS_IDLE;
      os_cnt <= tmo_pkg::CNT_ZERO;
      oneshot <= 1'b0;
    end
    else if (ce_in)
    begin
      os_state <= next_os_state;
      oneshot <= (next_os_state == tmo_pkg::TMO_OS_PULSE);
      if (next_os_state != tmo_pkg::TMO_OS_PULSE)
      begin
        os_cnt <= tmo_pkg::CNT_ZERO;
      end
      else if (step)
      begin
        os_cnt <= os_cnt + tmo_pkg::CNT_ONE;
      end
    end
  end

  // Outputs straight from flip-flops.
  assign overflow_flag_out = flag;
  assign count_value_reg_out = cnt;
  assign match_capture_irq_out = irq;
  assign oneshot_out = oneshot;
endmodule

// ===== test/tmo_ctl_chk.sv
// Purpose: Port-level checks of the timer overflow flag and one-shot.
// Assumes: Mode bits {hi,lo}; one clock domain.
// Notes: win mirrors the post-wrap window in which flag clears are ignored.
`timescale 1ns/100ps
module tmo_chk (
  input wire logic clk_in, // Clock.
  input wire logic rst_in, // Reset.
  input wire logic ce_in, // Enable.
  input wire logic count_pulse_in, // Count step.
  input wire logic mode_select_hi_in, // Mode high.
  input wire logic mode_select_lo_in, // Mode low.
  input wire logic [15:0] compare_capture_reg_a_in, // Compare.
  input wire logic external_edge_input_in, // Edge pin.
  input wire logic flag_clear_in, // Flag clear.
  input wire logic oneshot_trig_in, // Trigger.
  input wire logic overflow_flag_out, // Flag.
  input wire logic [15:0] count_value_reg_out, // Counter.
  input wire logic match_capture_irq_out, // Match pulse.
  input wire logic oneshot_out // One-shot.
);
  wire logic [1:0] mode = {mode_select_hi_in, mode_select_lo_in}; // Mode code.
  logic win; // Window open after a wrap.
  logic [2:0] pin_sr; // Mirror of the three pin stages, newest at the bottom.
  logic pin_lvl; // Mirror of the filtered pin level.
  logic pin_rise; // Mirror of the registered filtered rise.
  logic pin_agree; // Second and third mirror stages agree.
  assign pin_agree = (pin_sr[1] == pin_sr[2]);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // An enabled count pulse; the counter takes it only outside mode 00.
  sequence s_step;
    ce_in && count_pulse_in;
  endsequence
  // Pin mirror, so that an edge clear in mode 01 is known here as well.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pin_sr <= 3'h0;
      pin_lvl <= 1'b0;
      pin_rise <= 1'b0;
    end
    else if (ce_in)
    begin
      pin_sr <= {pin_sr[1:0], external_edge_input_in};
      pin_lvl <= pin_agree ? pin_sr[2] : pin_lvl;
      pin_rise <= pin_agree && pin_sr[2] && !pin_lvl;
    end
  end
  // Opens on a wrap in any running mode, closes on a step, an edge clear or a stop.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      win <= 1'b0;
    end
    else if (ce_in && count_pulse_in && mode != 2'h0 && count_value_reg_out == 16'hFFFF)
    begin
      win <= 1'b1;
    end
    else if (ce_in && (count_pulse_in || mode == 2'h0 || (pin_rise && mode == 2'h1)))
    begin
      win <= 1'b0;
    end
  end
  a_wrap_sets_flag: assert property (s_step ##0 (count_value_reg_out == 16'hFFFF && mode != 2'h0)
    |=> overflow_flag_out && count_value_reg_out == 16'h0000) else $error("wrap did not set flag");
  a_match_clears: assert property (s_step ##0 (mode == 2'h3 && count_value_reg_out == compare_capture_reg_a_in)
    |=> count_value_reg_out == 16'h0000) else $error("match did not clear counter");
  a_irq_on_match: assert property (s_step ##0 (mode == 2'h3 && count_value_reg_out == compare_capture_reg_a_in)
    |=> match_capture_irq_out) else $error("match pulse missing");
  a_edge_clears: assert property (ce_in && pin_rise && mode == 2'h1 |=> count_value_reg_out == 16'h0000)
    else $error("edge did not clear counter");
  a_window_holds: assert property (win && mode != 2'h0 |=> overflow_flag_out)
    else $error("flag cleared inside window");
  a_clear_works: assert property (overflow_flag_out && flag_clear_in && ce_in && !win && !count_pulse_in
    |=> !overflow_flag_out) else $error("flag clear lost");
  a_flag_stays: assert property (overflow_flag_out && !flag_clear_in |=> overflow_flag_out)
    else $error("flag dropped by itself");
  a_os_start: assert property (ce_in && oneshot_trig_in && !oneshot_out && (mode == 2'h1 || mode == 2'h2)
    |=> oneshot_out) else $error("one-shot did not start");
  a_no_os_match: assert property (mode == 2'h3 && !oneshot_out |=> !oneshot_out)
    else $error("one-shot in match mode");
  a_stop_holds: assert property (mode == 2'h0 |=> $stable(count_value_reg_out))
    else $error("counter moved while stopped");
endmodule
bind tmo_ctl tmo_chk u_chk (.clk_in, .rst_in, .ce_in, .count_pulse_in, .mode_select_hi_in, .mode_select_lo_in,
  .compare_capture_reg_a_in, .external_edge_input_in, .flag_clear_in, .oneshot_trig_in, .overflow_flag_out,
  .count_value_reg_out, .match_capture_irq_out, .oneshot_out);

// ===== test/tmo_ctl_tb.sv
// Purpose: Directed bench for the timer overflow flag and one-shot.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: One full count trip brings the counter to FFFFH.
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, a, e); end end
module timer16_overflow_oneshot_ctl_tb_top;
  logic clk_in = 1'b0; // Clock.
  logic rst_in = 1'b1; // Reset.
  logic ce_in = 1'b1; // Clock enable.
  logic count_pulse_in = 1'b0; // Count step.
  logic [1:0] mode = 2'h0; // Mode code.
  logic [15:0] compare_capture_reg_a_in = 16'hFFFF; // Compare.
  logic external_edge_input_in = 1'b0; // Edge pin.
  logic flag_clear_in = 1'b0; // Flag clear.
  logic oneshot_trig_in = 1'b0; // Trigger.
  logic overflow_flag_out; // Flag.
  logic [15:0] count_value_reg_out; // Counter.
  logic oneshot_out; // One-shot.
  logic match_capture_irq_out; // Match pulse.
  int fails = 0; // Mismatches.
  int samples_checked = 0; // Comparisons.
  int cycles = 0; // Cycle count for the timeout.
  tmo_ctl dut (.clk_in, .rst_in, .ce_in, .count_pulse_in, .mode_select_hi_in(mode[1]),
    .mode_select_lo_in(mode[0]), .compare_capture_reg_a_in, .external_edge_input_in, .flag_clear_in,
    .oneshot_trig_in, .overflow_flag_out, .count_value_reg_out, .match_capture_irq_out, .oneshot_out);
  // Half-period toggle gives 5 ns.
  always #2.5 clk_in = ~clk_in;
  // Waits n edges, then steps off the edge.
  task tick(int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Prints the verdict and ends the run.
  task stop_test;
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 70000)
    begin
      fails++;
      stop_test();
    end
  end
  // Full trip, wrap by match at FFFFH, clears in and after the window.
  task t_wrap;
    mode = 2'h2;
    count_pulse_in = 1'b1;
    tick(65535);
    `CHK(overflow_flag_out, 1'b0)
    mode = 2'h3;
    tick(1);
    count_pulse_in = 1'b0;
    `CHK(count_value_reg_out, 16'h0000)
    `CHK(overflow_flag_out, 1'b1)
    flag_clear_in = 1'b1;
    tick(3);
    `CHK(overflow_flag_out, 1'b1)
    count_pulse_in = 1'b1;
    tick(1);
    count_pulse_in = 1'b0;
    `CHK(count_value_reg_out, 16'h0001)
    tick(2);
    `CHK(overflow_flag_out, 1'b0)
    flag_clear_in = 1'b0;
  endtask
  // Match clear below FFFFH leaves the flag; stop mode freezes the counter.
  task t_match_stop;
    compare_capture_reg_a_in = 16'h0003;
    count_pulse_in = 1'b1;
    tick(3);
    `CHK(count_value_reg_out, 16'h0000)
    `CHK(overflow_flag_out, 1'b0)
    `CHK(match_capture_irq_out, 1'b1)
    mode = 2'h0;
    tick(4);
    count_pulse_in = 1'b0;
    `CHK(count_value_reg_out, 16'h0000)
    `CHK(match_capture_irq_out, 1'b0)
    // A low clock enable freezes the counter even while it runs.
    mode = 2'h2;
    count_pulse_in = 1'b1;
    ce_in = 1'b0;
    tick(3);
    `CHK(count_value_reg_out, 16'h0000)
    ce_in = 1'b1;
    tick(1);
    count_pulse_in = 1'b0;
    `CHK(count_value_reg_out, 16'h0001)
  endtask
  // One-shot trigger in each running mode, pulse expected except in mode 11, ended by two steps.
  task t_oneshot;
    for (int i = 1; i < 4; i++)
    begin
      mode = 2'(i);
      oneshot_trig_in = 1'b1;
      tick(1);
      oneshot_trig_in = 1'b0;
      `CHK(oneshot_out, 1'(i != 3))
      count_pulse_in = 1'b1;
      tick(2);
      count_pulse_in = 1'b0;
      tick(2);
      `CHK(oneshot_out, 1'b0)
    end
  endtask
  // Edge mode: a rising pin clears the counter without touching the flag.
  task t_edge;
    mode = 2'h1;
    count_pulse_in = 1'b1;
    tick(5);
    count_pulse_in = 1'b0;
    external_edge_input_in = 1'b1;
    tick(8);
    `CHK(count_value_reg_out, 16'h0000)
    `CHK(overflow_flag_out, 1'b0)
  endtask
  // Main sequence.
  initial
  begin
    tick(8);
    rst_in = 1'b0;
    t_wrap();
    t_match_stop();
    t_oneshot();
    t_edge();
    stop_test();
  end
endmodule
